// >>> pkg/scic_defs.svh
/*
  Constants for the sync and clock input control block: reset values,
  configuration field positions, field widths and the fifo depth.
  Assumes inclusion by bare name from the package and the core files.
*/
`ifndef SCIC_DEFS_SVH
`define SCIC_DEFS_SVH

`define SCIC_HSYNC_POL_BIT       7
`define SCIC_CFG0F_RESET         8'h00
`define SCIC_EXT_CLAMP_RESET     1'h0
`define SCIC_CLAMP_POL_RESET     1'h1
`define SCIC_COAST_POL_RESET     1'h1
`define SCIC_EXT_CLK_SEL_RESET   1'h0
`define SCIC_CNT_WIDTH           8
`define SCIC_SAMPLE_WIDTH        8
`define SCIC_FIFO_DEPTH          16
`define SCIC_SAMPLE_PHASE_WIDTH  5

`endif

// >>> pkg/scic_pkg.sv
/*
  Types shared by the sync and clock input control block.
  Assumes scic_defs.svh is on the include path.
*/
`include "scic_defs.svh"

package scic_pkg;

  typedef struct packed {
    logic [`SCIC_SAMPLE_WIDTH-1:0] red;
    logic [`SCIC_SAMPLE_WIDTH-1:0] green;
    logic [`SCIC_SAMPLE_WIDTH-1:0] blue;
  } scic_pixel_type;

  typedef struct packed {
    scic_pixel_type pixel;
    logic           odd;
  } scic_sample_type;

  typedef struct packed {
    logic                                 external_clamp_enable;
    logic                                 clamp_strobe_polarity;
    logic                                 coast_polarity;
    logic                                 external_pixel_clock_select;
    logic [`SCIC_CNT_WIDTH-1:0]           clamp_delay;
    logic [`SCIC_CNT_WIDTH-1:0]           clamp_duration;
    logic [`SCIC_SAMPLE_PHASE_WIDTH-1:0]  sample_phase;
  } scic_config_type;

  typedef enum logic [1:0] {
    SCIC_CLAMP_IDLE,
    SCIC_CLAMP_DELAY,
    SCIC_CLAMP_ACTIVE
  } scic_clamp_state_type;

endpackage : scic_pkg

// >>> core/scic_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides; read data registered.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps

module scic_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;
  logic             load;

  // out_data register acts as the head slot, so count includes it
  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign load      = (count_q > (AW+1)'(1)) || ((count_q == (AW+1)'(1)) && !out_valid);

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
  endfunction : bump

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wr_q <= '0;
    end
    else if (push)
    begin
      wr_q <= bump(wr_q);
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      count_q <= '0;
    end
    else
    begin
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // head register refills from memory when empty or being drained
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
      rd_q      <= '0;
    end
    else if ((!out_valid || pop) && load)
    begin
      out_valid <= 1'b1;
      out_data  <= mem_q[rd_q];
      rd_q      <= bump(rd_q);
    end
    else if (pop)
    begin
      out_valid <= 1'b0;
    end
  end

endmodule : scic_fifo

// >>> core/scic_core.sv
/*
  Sync and clock input control: hsync leading-edge detection, clamp gating
  or internal clamp timing, coast qualification, pixel clock source select,
  sampling clock inversion and even/odd sample steering to ports A and B.
  Assumes all pins but the generated clock, the samples and port_ready reach this logic through the two-flop synchronisers here;
  the clock itself stands in for the pixel clock; configuration comes from
  a serial control block elsewhere.
*/
// Operation
// - hsync sense from bit 7 of 0Fh
// - only leading hsync edge is the reference; the internal clamp timer here counts from the trailing edge
// - polarity 0 falling, 1 rising leading edge
// - external clamp honoured only when enabled; resets 0
// - disabled: internal clamp delay then duration
// - clamp strobe level set by polarity bit
// - coast holds clock generator frequency and phase
// - coast sense from polarity bit; resets 1
// - select bit picks external pixel clock
// - phase adjustment stays active on external clock
// - invert input shifts sampling by half period
// - alternate frames sample odd then even pixels
// - even to port A, odd to port B
// - drive true and complementary data clocks
`timescale 1ns/1ps
`include "scic_defs.svh"

module scic_core #(
  parameter int CNT_WIDTH  = `SCIC_CNT_WIDTH,
  parameter int FIFO_DEPTH = `SCIC_FIFO_DEPTH
) (
  input  wire logic                                  clock,
  input  wire logic                                  reset,
  input  wire logic [7:0]                            config_0f,
  input  wire scic_pkg::scic_config_type             config_in,
  input  wire logic                                  hsync_in,
  input  wire logic                                  clamp_strobe_in,
  input  wire logic                                  coast_in,
  input  wire logic                                  external_pixel_clock_in,
  input  wire logic                                  generated_pixel_clock_in,
  input  wire logic                                  sampling_clock_invert,
  input  wire scic_pkg::scic_pixel_type              adc_sample,
  input  wire logic                                  adc_sample_valid,
  output logic                                       adc_sample_ready,
  output logic                                       hsync_leading,
  output logic                                       clamp_active,
  output logic                                       pll_hold,
  output logic                                       pixel_clock_source,
  output logic                                       sampling_clock_inverted,
  output logic [`SCIC_SAMPLE_PHASE_WIDTH-1:0]        sample_phase_out,
  output scic_pkg::scic_pixel_type                   port_a,
  output scic_pkg::scic_pixel_type                   port_b,
  output logic                                       output_data_strobe,
  output logic                                       output_data_strobe_n,
  input  wire logic                                  port_ready
);

  // the hsync, clamp strobe and coast pins share one qualification against their polarity bits
  function automatic logic asserted(input logic level, input logic active_high);
    asserted = active_high ? level : !level;
  endfunction : asserted

  // counters stop on one, not zero, so a window lasts exactly its count
  function automatic logic last_count(input logic [CNT_WIDTH-1:0] count);
    last_count = (count <= CNT_WIDTH'(1));
  endfunction : last_count

  // two-flop synchronisers for pins
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  logic       hsync_s;
  logic       clamp_s;
  logic       coast_s;
  logic       external_pixel_clock_select_s;
  logic       invert_s;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      // hsync flops start at the pin's idle level so no false edge follows reset
      pin_meta_q <= {!config_0f[`SCIC_HSYNC_POL_BIT], 4'h0};
      pin_sync_q <= {!config_0f[`SCIC_HSYNC_POL_BIT], 4'h0};
    end
    else
    begin
      pin_meta_q <= {hsync_in, clamp_strobe_in, coast_in, external_pixel_clock_in,
                     sampling_clock_invert};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign {hsync_s, clamp_s, coast_s, external_pixel_clock_select_s, invert_s} = pin_sync_q;

  // normalise hsync so 1 means active
  logic hsync_act;
  logic hsync_act_q;
  logic hsync_trailing;

  // polarity is not synchronised: flipping it live can fake one edge
  assign hsync_act = asserted(hsync_s, config_0f[`SCIC_HSYNC_POL_BIT]);

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      hsync_act_q <= 1'b0;
    end
    else
    begin
      hsync_act_q <= hsync_act;
    end
  end

  assign hsync_trailing = hsync_act_q && !hsync_act;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      hsync_leading <= 1'b0;
    end
    else
    begin
      hsync_leading <= hsync_act && !hsync_act_q;
    end
  end

  // internal clamp timer: delay then duration from hsync trailing edge
  scic_pkg::scic_clamp_state_type clamp_state_q;
  logic [CNT_WIDTH-1:0]           clamp_cnt_q;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      clamp_state_q <= scic_pkg::SCIC_CLAMP_IDLE;
      clamp_cnt_q   <= '0;
    end
    else if (hsync_trailing)
    begin
      // restart on every trailing edge; zero delay goes straight to clamp
      clamp_state_q <= (config_in.clamp_delay == '0) ? scic_pkg::SCIC_CLAMP_ACTIVE
                                                     : scic_pkg::SCIC_CLAMP_DELAY;
      clamp_cnt_q   <= (config_in.clamp_delay == '0) ? CNT_WIDTH'(config_in.clamp_duration)
                                                     : CNT_WIDTH'(config_in.clamp_delay);
    end
    else
    begin
      unique case (clamp_state_q)
        scic_pkg::SCIC_CLAMP_IDLE:
        begin
          clamp_cnt_q <= '0;
        end
        scic_pkg::SCIC_CLAMP_DELAY:
        begin
          if (last_count(clamp_cnt_q))
          begin
            clamp_state_q <= scic_pkg::SCIC_CLAMP_ACTIVE;
            clamp_cnt_q   <= CNT_WIDTH'(config_in.clamp_duration);
          end
          else
          begin
            clamp_cnt_q <= clamp_cnt_q - CNT_WIDTH'(1);
          end
        end
        scic_pkg::SCIC_CLAMP_ACTIVE:
        begin
          if (last_count(clamp_cnt_q))
          begin
            clamp_state_q <= scic_pkg::SCIC_CLAMP_IDLE;
            clamp_cnt_q   <= '0;
          end
          else
          begin
            clamp_cnt_q <= clamp_cnt_q - CNT_WIDTH'(1);
          end
        end
        default:
        begin
          clamp_state_q <= scic_pkg::SCIC_CLAMP_IDLE;
        end
      endcase
    end
  end

  logic internal_clamp;
  logic external_clamp;

  // zero duration never opens the window
  assign internal_clamp = (clamp_state_q == scic_pkg::SCIC_CLAMP_ACTIVE)
                          && (clamp_cnt_q != '0);
  assign external_clamp = asserted(clamp_s, config_in.clamp_strobe_polarity);

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      clamp_active <= 1'b0;
    end
    else
    begin
      clamp_active <= config_in.external_clamp_enable ? external_clamp : internal_clamp;
    end
  end

  // coast and clock source selection
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pll_hold                <= 1'b0;
      pixel_clock_source      <= 1'b0;
      sampling_clock_inverted <= 1'b0;
      sample_phase_out        <= '0;
    end
    else
    begin
      pll_hold                <= asserted(coast_s, config_in.coast_polarity);
      // level seen on the selected source; the clock mux itself sits in the analog
      pixel_clock_source      <= config_in.external_pixel_clock_select ? external_pixel_clock_select_s
                                                                       : generated_pixel_clock_in;
      sampling_clock_inverted <= invert_s;
      sample_phase_out        <= config_in.sample_phase;
    end
  end

  // sample steering through the fifo; parity flips with inversion, so
  // toggling it per frame captures the other half of the pixels
  logic                      even_odd_q;
  scic_pkg::scic_sample_type fifo_in;
  scic_pkg::scic_sample_type fifo_out;
  logic                      fifo_out_valid;
  logic                      fifo_out_ready;
  logic                      drain;

  always_ff @(posedge clock)
  begin
    if (reset || hsync_leading)
    begin
      even_odd_q <= 1'b0;
    end
    else if (adc_sample_valid && adc_sample_ready)
    begin
      even_odd_q <= !even_odd_q;
    end
  end

  assign fifo_in.pixel = adc_sample;
  assign fifo_in.odd   = even_odd_q ^ invert_s;

  scic_fifo #(
    .WIDTH ($bits(scic_pkg::scic_sample_type)),
    .DEPTH (FIFO_DEPTH)
  ) scic_fifo_i (
    .clock     (clock),
    .reset     (reset),
    .in_data   (fifo_in),
    .in_valid  (adc_sample_valid),
    .in_ready  (adc_sample_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  assign fifo_out_ready = port_ready;
  assign drain          = fifo_out_valid && fifo_out_ready;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      port_a <= '0;
      port_b <= '0;
    end
    else if (drain)
    begin
      if (fifo_out.odd)
      begin
        port_b <= fifo_out.pixel;
      end
      else
      begin
        port_a <= fifo_out.pixel;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      output_data_strobe   <= 1'b0;
      output_data_strobe_n <= 1'b1;
    end
    else
    begin
      output_data_strobe   <= drain;
      output_data_strobe_n <= !drain;
    end
  end

endmodule : scic_core

// >>> verif/scic_monitor.sv
/*
  Port-level checker for scic_core, bound after the module.
  Assumes pin and config changes are held a few cycles before they are used.
*/
`timescale 1ns/1ps
`include "scic_defs.svh"

module scic_monitor (
  input wire logic                                clock,
  input wire logic                                reset,
  input wire logic [7:0]                          config_0f,
  input wire scic_pkg::scic_config_type           config_in,
  input wire logic                                hsync_in,
  input wire logic                                clamp_strobe_in,
  input wire logic                                coast_in,
  input wire logic                                external_pixel_clock_in,
  input wire logic                                generated_pixel_clock_in,
  input wire logic                                sampling_clock_invert,
  input wire logic                                hsync_leading,
  input wire logic                                clamp_active,
  input wire logic                                pll_hold,
  input wire logic                                pixel_clock_source,
  input wire logic                                sampling_clock_inverted,
  input wire logic [`SCIC_SAMPLE_PHASE_WIDTH-1:0] sample_phase_out,
  input wire logic                                output_data_strobe,
  input wire logic                                output_data_strobe_n
);
  logic [2:0] up_q;
  logic       ok;

  // the sync flops still hold reset values for a few edges after release
  always_ff @(posedge clock)
    if (reset)
      up_q <= 3'h0;
    else if (up_q != 3'h4)
      up_q <= up_q + 3'h1;

  assign ok = (up_q == 3'h4);

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  sequence lead_rise;
    ok && config_0f[7] && $rose(hsync_in);
  endsequence
  sequence lead_fall;
    ok && !config_0f[7] && $fell(hsync_in);
  endsequence
  sequence ext_held;
    (config_in.external_clamp_enable && $stable(config_in.clamp_strobe_polarity)) [*4];
  endsequence

  chk_lead_rise: assert property (lead_rise |-> ##3 hsync_leading)
    else $error("rising leading edge missed");
  chk_lead_fall: assert property (lead_fall |-> ##3 hsync_leading)
    else $error("falling leading edge missed");
  chk_trail_quiet: assert property (ok && !config_0f[7] && $rose(hsync_in) |-> ##3 !hsync_leading)
    else $error("trailing edge made a pulse");
  chk_lead_single: assert property (hsync_leading |=> !hsync_leading)
    else $error("leading pulse too long");
  chk_ext_clamp: assert property (ext_held ##0 ok |-> clamp_active ==
    ($past(clamp_strobe_in, 3) == $past(config_in.clamp_strobe_polarity, 3)))
    else $error("external clamp not followed");
  chk_coast_hold: assert property ($stable(config_in.coast_polarity) [*4] ##0 ok |->
    pll_hold == ($past(coast_in, 3) == config_in.coast_polarity))
    else $error("coast hold wrong");
  chk_clk_source: assert property (config_in.external_pixel_clock_select [*4] ##0 ok |->
    pixel_clock_source == $past(external_pixel_clock_in, 3))
    else $error("external clock not selected");
  chk_gen_source: assert property ((!config_in.external_pixel_clock_select) [*2] ##0 ok |->
    pixel_clock_source == $past(generated_pixel_clock_in))
    else $error("generated clock not selected");
  chk_invert_path: assert property (ok |-> sampling_clock_inverted == $past(sampling_clock_invert, 3))
    else $error("invert not passed");
  chk_phase_kept: assert property (ok |-> sample_phase_out == $past(config_in.sample_phase))
    else $error("phase not passed");
  chk_strobe_pair: assert property (output_data_strobe_n != output_data_strobe)
    else $error("strobe pair not complementary");
endmodule : scic_monitor

bind scic_core scic_monitor scic_monitor_i (.clock, .reset, .config_0f, .config_in, .hsync_in,
  .clamp_strobe_in, .coast_in, .external_pixel_clock_in, .generated_pixel_clock_in,
  .sampling_clock_invert, .hsync_leading,
  .clamp_active, .pll_hold, .pixel_clock_source, .sampling_clock_inverted, .sample_phase_out,
  .output_data_strobe, .output_data_strobe_n);

// >>> verif/scic_sync_source.sv
/*
  Timing source model: one hsync line pulse per go, back porch clamp strobe,
  free running external pixel clock. Assumes go is a one-cycle request.
*/
`timescale 1ns/1ps

module scic_sync_source (
  input  wire logic clock,
  input  wire logic go,
  input  wire logic sync_high,
  input  wire logic strobe_high,
  output logic      hsync_in,
  output logic      clamp_strobe_in,
  output logic      external_pixel_clock_in
);
  logic [7:0] left_q = 8'h00;
  logic [1:0] div_q  = 2'h0;
  logic       ext_q  = 1'b0;

  assign external_pixel_clock_in = ext_q;

  always @(negedge clock)
  begin
    if (go)
      left_q <= 8'h0E;
    else if (left_q != 8'h00)
      left_q <= left_q - 8'h01;
    div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
    if (div_q == 2'h2)
      ext_q <= ~ext_q;
  end

  // six cycles of sync, then the porch
  assign hsync_in = (left_q > 8'h08) ~^ sync_high;
  // strobe only in the back porch, where inputs sit at reference level
  assign clamp_strobe_in = (left_q inside {[8'h02:8'h05]}) ~^ strobe_high;
endmodule : scic_sync_source

// >>> verif/test_scic_core.sv
/*
  Random and corner tests of scic_core with a timing source model.
  Assumes scic_monitor is bound to the core by its own file.
*/
`timescale 1ns/1ps

module test_scic_core;
  logic                      clock = 1'b0;
  logic                      reset = 1'b1;
  logic [7:0]                config_0f = 8'h00;
  scic_pkg::scic_config_type config_in = scic_pkg::scic_config_type'({4'h6, 21'h0});
  logic                      go = 1'b0;
  logic                      coast_in = 1'b0;
  logic                      generated_pixel_clock_in = 1'b0;
  logic                      sampling_clock_invert = 1'b0;
  scic_pkg::scic_pixel_type  adc_sample = '0;
  logic                      adc_sample_valid = 1'b0;
  logic                      port_ready = 1'b1;
  logic                      cl_d = 1'b0;
  logic                      hsync_in, clamp_strobe_in, external_pixel_clock_in;
  logic                      adc_sample_ready, hsync_leading, clamp_active, pll_hold;
  logic                      pixel_clock_source, sampling_clock_inverted;
  logic                      output_data_strobe, output_data_strobe_n;
  logic [4:0]                sample_phase_out;
  scic_pkg::scic_pixel_type  port_a, port_b;
  scic_pkg::scic_sample_type exp_q[$];
  scic_pkg::scic_sample_type e;
  int                        miscompares = 0, n_tests = 0, cyc = 0;
  int                        n_lead, n_clamp, rise, go_cyc, n, d, w;
  // edges from go to first clamp sample: go, 6 sync, 2 flops, detect, load, register
  localparam int             CLAMP_LAG = 12;

  scic_core scic_core_i (.clock, .reset, .config_0f, .config_in, .hsync_in, .clamp_strobe_in,
    .coast_in, .external_pixel_clock_in, .generated_pixel_clock_in, .sampling_clock_invert,
    .adc_sample, .adc_sample_valid, .adc_sample_ready, .hsync_leading, .clamp_active, .pll_hold,
    .pixel_clock_source, .sampling_clock_inverted, .sample_phase_out, .port_a, .port_b,
    .output_data_strobe, .output_data_strobe_n, .port_ready);
  scic_sync_source scic_sync_source_i (.clock, .go, .sync_high(config_0f[7]),
    .strobe_high(config_in.clamp_strobe_polarity), .hsync_in, .clamp_strobe_in,
    .external_pixel_clock_in);

  always #25 clock = ~clock;

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic line;
    go <= 1'b1;
    go_cyc = cyc;
    @(negedge clock) go <= 1'b0;
    repeat (40) @(negedge clock);
  endtask : line

  always @(posedge clock)
  begin
    cyc++;
    if (hsync_leading) n_lead++;
    if (clamp_active) n_clamp++;
    if (clamp_active && !cl_d) rise = cyc;
    cl_d = clamp_active;
    if (output_data_strobe && exp_q.size() == 0) cmp(32'h1, 32'h0);
    if (output_data_strobe && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      cmp(e.odd ? port_b : port_a, e.pixel);
    end
  end

  always @(negedge clock)
  begin
    generated_pixel_clock_in <= 1'($urandom);
    config_in.sample_phase <= 5'($urandom);
  end

  initial
  begin
    n = $urandom(32'hDA9C);
    repeat (3) @(negedge clock);
    cmp({clamp_active, pll_hold, hsync_leading, output_data_strobe_n}, 4'h1);
    reset = 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      config_0f[7] = p[0];
      repeat (6) @(negedge clock);
      n_lead = 0;
      line();
      cmp(n_lead, 1);
      $display("hsync polarity %0d done", p);
    end
    config_in.external_clamp_enable = 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      config_in.clamp_strobe_polarity = p[0];
      repeat (6) @(negedge clock);
      n_clamp = 0;
      line();
      cmp(n_clamp, 4);
      $display("external clamp %0d done", p);
    end
    config_in.external_clamp_enable = 1'b0;
    // corner cases: zero delay at k 4, zero duration at k 5
    for (int k = 0; k < 6; k++)
    begin
      d = (k == 4) ? 0 : $urandom_range(8, 1);
      w = (k == 5) ? 0 : $urandom_range(8, 1);
      config_in.clamp_delay = 8'(d);
      config_in.clamp_duration = 8'(w);
      repeat (6) @(negedge clock);
      n_clamp = 0;
      line();
      cmp(n_clamp, w);
      if (w != 0) cmp(rise - go_cyc - d, CLAMP_LAG);
      $display("internal clamp %0d done", k);
    end
    for (int p = 0; p < 4; p++)
    begin
      config_in.coast_polarity = p[1];
      coast_in = p[0];
      repeat (5) @(negedge clock);
      cmp(pll_hold, p[0] == p[1]);
    end
    $display("coast done");
    config_in.external_pixel_clock_select = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      sampling_clock_invert = i[0];
      repeat (6) @(negedge clock);
      line();
      port_ready = 1'b0;
      n = 0;
      while (n < 40)
      begin
        @(negedge clock);
        if (!adc_sample_ready) break;
        adc_sample = 24'($urandom);
        adc_sample_valid = 1'b1;
        exp_q.push_back({adc_sample, n[0] ^ i[0]});
        n++;
      end
      adc_sample_valid = 1'b0;
      cmp(n, 16);
      // random stalls while draining
      repeat (120) @(negedge clock) port_ready = 1'($urandom);
      port_ready = 1'b1;
      repeat (6) @(negedge clock);
      cmp(exp_q.size(), 0);
      $display("samples invert %0d done", i);
    end
    tally_and_finish();
  end

  // several times the expected run of about 900 cycles
  initial
  begin
    #300000;
    miscompares++;
    tally_and_finish();
  end
endmodule : test_scic_core
